/* aitp_pkg.sv */
/*
 * Shared constants and types of the two-wire converter target port.
 * Assumes a 100 MHz system clock and a free-running modulator clock.
 */
package aitp_pkg;

   // ============================================================
   // Target addressing
   localparam logic [2:0] ADDR_PREFIX  = 3'h4;   // Upper address bits 100
   localparam logic [6:0] GCALL_ADDR   = 7'h00;  // General-call address
   localparam logic [7:0] GCALL_RESET  = 8'h06;  // General-call reset byte
   localparam logic [1:0] STRAP_GND    = 2'h0;
   localparam logic [1:0] STRAP_SUPPLY = 2'h1;
   localparam logic [1:0] STRAP_DATA   = 2'h2;
   localparam logic [1:0] STRAP_CLOCK  = 2'h3;

   // ============================================================
   // Framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int         FILT_LEN      = 3;      // Glitch filter samples
   localparam int         RESULT_W      = 16;     // Two's-complement result

   // ============================================================
   // Timing
   localparam int SYS_CLK_MHZ        = 100;
   localparam int READY_RELEASE_NS   = 2000;    // ready_release_pulse
   localparam int READY_RELEASE_CYC  =
      (READY_RELEASE_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int TIMEOUT_NORMAL_MOD = 14000;   // modulator_period counts
   localparam int TIMEOUT_TURBO_MOD  = 28000;
   localparam int TIMEOUT_W          = 15;

   // ============================================================
   // Transaction states
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK,
      ST_IGNORE
   } aitp_state_t;

endpackage

/* aitp_sync_filt.sv */
/*
 * Two-flop synchroniser followed by a majority-free glitch filter.
 * Assumes an asynchronous input; output changes only after STAGES
 * equal samples.
 */
`timescale 1ns/1ps
module aitp_sync_filt
   import aitp_pkg::*;
#(
   parameter int   STAGES  = FILT_LEN,
   parameter logic RST_VAL = 1'b1
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Asynchronous input and filtered output
   input  wire logic din,
   output logic      dout
);

   initial
   begin
      if (STAGES < 2)
         $error("aitp_sync_filt needs at least two filter stages");
   end

   logic              meta_ff;
   logic              sync_ff;
   logic [STAGES-1:0] hist_ff;
   logic              out_ff;
   wire               all_hi = &hist_ff;
   wire               all_lo = ~|hist_ff;

   // ============================================================
   // Synchroniser, history and filtered level
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
         hist_ff <= {STAGES{RST_VAL}};
         out_ff  <= RST_VAL;
      end
      else
      begin
         meta_ff <= din;
         sync_ff <= meta_ff;
         hist_ff <= {hist_ff[STAGES-2:0], sync_ff};
         out_ff  <= all_hi ? 1'b1 : (all_lo ? 1'b0 : out_ff);
      end
   end

   assign dout = out_ff;

endmodule

/* aitp_target_port.sv */
/*
 * Two-wire serial target port of a delta-sigma converter: address decode
 * from two four-state straps, START/STOP framing, byte transfer with
 * acknowledge, general-call reset, idle timeout, data-ready output.
 * Assumes external pull-ups on the bus lines, a conversion path on
 * clk_sys and a free-running modulator clock clk_mod.
 */
`timescale 1ns/1ps
module aitp_target_port
   import aitp_pkg::*;
#(
   parameter int TIMEOUT_NORMAL = TIMEOUT_NORMAL_MOD,
   parameter int TIMEOUT_TURBO  = TIMEOUT_TURBO_MOD
)
(
   // System clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // Modulator clock, timeout domain
   input  wire logic                clk_mod,
   input  wire logic                turbo_mode,
   // Bus lines; clock is input only
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe,
   // Address straps, sensed levels
   input  wire logic                addr_strap_low,
   input  wire logic                addr_strap_high,
   // Conversion path
   input  wire logic                result_valid,
   input  wire logic [RESULT_W-1:0] result_data,
   input  wire logic                release_req,
   // Open-drain ready output
   output logic                     result_ready_n_out,
   output logic                     result_ready_n_oe,
   // Command side
   output logic [7:0]               cmd_byte,
   output logic                     cmd_valid,
   output logic                     soft_reset,
   output logic [6:0]               own_addr
);

   initial
   begin
      if (TIMEOUT_NORMAL < 2 || TIMEOUT_TURBO >= (1 << TIMEOUT_W))
         $error("aitp_target_port timeout limits out of range");
   end

   localparam logic [TIMEOUT_W-1:0] TO_NORMAL = TIMEOUT_W'(TIMEOUT_NORMAL);
   localparam logic [TIMEOUT_W-1:0] TO_TURBO  = TIMEOUT_W'(TIMEOUT_TURBO);
   localparam logic [11:0]          RDY_CYC   = 12'(READY_RELEASE_CYC);

   // ============================================================
   // Input conditioning
   logic scl_f;
   logic sda_f;
   logic strap_lo_f;
   logic strap_hi_f;

   // Bus lines and straps share one pipeline depth; lag far below a bit time
   aitp_sync_filt #(.STAGES(FILT_LEN), .RST_VAL(1'b1)) u_scl
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (scl_in),
      .dout  (scl_f)
   );
   aitp_sync_filt #(.STAGES(FILT_LEN), .RST_VAL(1'b1)) u_sda
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (sda_in),
      .dout  (sda_f)
   );
   aitp_sync_filt #(.STAGES(FILT_LEN), .RST_VAL(1'b0)) u_strap_lo
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (addr_strap_low),
      .dout  (strap_lo_f)
   );
   aitp_sync_filt #(.STAGES(FILT_LEN), .RST_VAL(1'b0)) u_strap_hi
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (addr_strap_high),
      .dout  (strap_hi_f)
   );

   // ============================================================
   // Registers
   logic                scl_d_ff;
   logic                sda_d_ff;
   logic [1:0]          strap_d_ff;
   aitp_state_t         state_ff,    nxt_state;
   logic [3:0]          cnt_ff,      nxt_cnt;
   logic [7:0]          rx_sh_ff,    nxt_rx_sh;
   logic [7:0]          tx_sh_ff,    nxt_tx_sh;
   logic                oe_ff,       nxt_oe;
   logic                rw_ff,       nxt_rw;
   logic                gc_ff,       nxt_gc;
   logic                idx_ff,      nxt_idx;
   logic                nack_ff,     nxt_nack;
   logic [1:0]          pre_ff,      nxt_pre;
   logic [1:0]          post_ff,     nxt_post;
   logic [6:0]          addr_ff,     nxt_addr;
   logic [RESULT_W-1:0] word_ff,     nxt_word;
   logic [7:0]          cmd_ff,      nxt_cmd;
   logic                cmd_vld_ff,  nxt_cmd_vld;
   logic                srst_ff,     nxt_srst;
   logic                latch_ff,    nxt_latch;
   logic                rdy_oe_ff;
   logic                pend_ff;
   logic [11:0]         hold_ff;
   logic                act_tgl_ff;
   logic                busy_ff;
   logic [2:0]          to_sync_ff;

   // ============================================================
   // Bus event decode
   wire start_det = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
   wire stop_det  = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
   wire scl_rise  = scl_f & ~scl_d_ff;
   wire scl_fall  = ~scl_f & scl_d_ff;
   wire line_act  = (scl_f ^ scl_d_ff) | (sda_f ^ sda_d_ff);
   wire timeout   = to_sync_ff[2] ^ to_sync_ff[1];
   wire first_fall = (state_ff == ST_ADDR) && (cnt_ff == 4'h0) && scl_fall;
   wire byte_done = (cnt_ff == BITS_PER_BYTE) && scl_fall;

   // Four-state strap: before START, after START, at first clock fall
   function automatic logic [1:0] strap_code(input logic pre, input logic post,
                                             input logic fall);
      logic [1:0] code;
      code = STRAP_CLOCK;
      if (!pre)
         code = STRAP_GND;
      else if (!post)
         code = STRAP_DATA;
      else if (fall)
         code = STRAP_SUPPLY;
      return code;
   endfunction

   // Address taken at first clock fall of the address byte
   wire [6:0] strap_addr = {ADDR_PREFIX,
                            strap_code(pre_ff[1], post_ff[1], strap_hi_f),
                            strap_code(pre_ff[0], post_ff[0], strap_lo_f)};
   wire addr_hit  = (rx_sh_ff[7:1] == addr_ff);
   wire gc_hit    = (rx_sh_ff[7:1] == GCALL_ADDR) && !rx_sh_ff[0];
   wire [7:0] next_tx = idx_ff ? word_ff[7:0] : word_ff[15:8];

   // ============================================================
   // Transaction sequencer
   always_comb
   begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_rx_sh   = rx_sh_ff;
      nxt_tx_sh   = tx_sh_ff;
      nxt_oe      = oe_ff;
      nxt_rw      = rw_ff;
      nxt_gc      = gc_ff;
      nxt_idx     = idx_ff;
      nxt_nack    = nack_ff;
      nxt_pre     = pre_ff;
      nxt_post    = post_ff;
      nxt_addr    = addr_ff;
      nxt_word    = word_ff;
      nxt_cmd     = cmd_ff;
      nxt_cmd_vld = 1'b0;
      nxt_srst    = 1'b0;
      nxt_latch   = 1'b0;
      if (timeout)
      begin
         // Interface abandons the transaction
         nxt_state = ST_IDLE;
         nxt_oe    = 1'b0;
      end
      else if (start_det)
      begin
         // Strap levels just before and just after START
         nxt_state = ST_ADDR;
         nxt_cnt   = 4'h0;
         nxt_oe    = 1'b0;
         nxt_pre   = strap_d_ff;
         nxt_post  = {strap_hi_f, strap_lo_f};
      end
      else if (stop_det)
      begin
         nxt_state = ST_IDLE;
         nxt_oe    = 1'b0;
      end
      else
      begin
         case (state_ff)
            ST_IDLE, ST_IGNORE:
            begin
               nxt_oe = 1'b0;
            end
            ST_ADDR:
            begin
               if (first_fall)
                  nxt_addr = strap_addr;
               if (scl_rise)
               begin
                  nxt_rx_sh = {rx_sh_ff[6:0], sda_f};
                  nxt_cnt   = cnt_ff + 4'h1;
               end
               else if (byte_done)
               begin
                  nxt_rw = rx_sh_ff[0];
                  nxt_gc = gc_hit;
                  if (addr_hit || gc_hit)
                  begin
                     nxt_oe    = 1'b1;
                     nxt_state = ST_ADDR_ACK;
                     if (addr_hit && rx_sh_ff[0])
                     begin
                        nxt_word  = result_data;
                        nxt_latch = 1'b1;
                     end
                  end
                  else
                     nxt_state = ST_IGNORE;
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_cnt = 4'h0;
                  nxt_idx = 1'b1;
                  if (rw_ff)
                  begin
                     nxt_tx_sh = word_ff[15:8];
                     nxt_oe    = ~word_ff[15];
                     nxt_state = ST_RD_BYTE;
                  end
                  else
                  begin
                     nxt_oe    = 1'b0;
                     nxt_state = ST_WR_BYTE;
                  end
               end
            end
            ST_WR_BYTE:
            begin
               if (scl_rise)
               begin
                  nxt_rx_sh = {rx_sh_ff[6:0], sda_f};
                  nxt_cnt   = cnt_ff + 4'h1;
               end
               else if (byte_done)
               begin
                  // Byte latched at its eighth fall
                  nxt_cmd     = rx_sh_ff;
                  nxt_cmd_vld = !gc_ff;
                  nxt_srst    = gc_ff && (rx_sh_ff == GCALL_RESET);
                  nxt_oe      = 1'b1;
                  nxt_state   = ST_WR_ACK;
               end
            end
            ST_WR_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_oe    = 1'b0;
                  nxt_cnt   = 4'h0;
                  nxt_state = gc_ff ? ST_IGNORE : ST_WR_BYTE;
               end
            end
            ST_RD_BYTE:
            begin
               if (scl_rise)
                  nxt_cnt = cnt_ff + 4'h1;
               else if (byte_done)
               begin
                  nxt_oe    = 1'b0;
                  nxt_state = ST_RD_ACK;
               end
               else if (scl_fall)
               begin
                  nxt_oe    = ~tx_sh_ff[6];
                  nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
                  nxt_nack = sda_f;
               else if (scl_fall)
               begin
                  nxt_cnt = 4'h0;
                  if (nack_ff)
                     nxt_state = ST_IGNORE;
                  else
                  begin
                     nxt_tx_sh = next_tx;
                     nxt_oe    = ~next_tx[7];
                     nxt_idx   = ~idx_ff;
                     nxt_state = ST_RD_BYTE;
                  end
               end
            end
            default:
            begin
               nxt_state = ST_IDLE;
               nxt_oe    = 1'b0;
            end
         endcase
      end
   end

   // ============================================================
   // Sequencer state
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_d_ff   <= 1'b1;
         sda_d_ff   <= 1'b1;
         strap_d_ff <= 2'h0;
         state_ff   <= ST_IDLE;
         cnt_ff     <= 4'h0;
         rx_sh_ff   <= 8'h00;
         tx_sh_ff   <= 8'h00;
         oe_ff      <= 1'b0;
         rw_ff      <= 1'b0;
         gc_ff      <= 1'b0;
         idx_ff     <= 1'b0;
         nack_ff    <= 1'b0;
         pre_ff     <= 2'h0;
         post_ff    <= 2'h0;
         addr_ff    <= {ADDR_PREFIX, STRAP_GND, STRAP_GND};
         word_ff    <= 16'h0000;
         cmd_ff     <= 8'h00;
         cmd_vld_ff <= 1'b0;
         srst_ff    <= 1'b0;
         latch_ff   <= 1'b0;
      end
      else
      begin
         scl_d_ff   <= scl_f;
         sda_d_ff   <= sda_f;
         strap_d_ff <= {strap_hi_f, strap_lo_f};
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         rx_sh_ff   <= nxt_rx_sh;
         tx_sh_ff   <= nxt_tx_sh;
         oe_ff      <= nxt_oe;
         rw_ff      <= nxt_rw;
         gc_ff      <= nxt_gc;
         idx_ff     <= nxt_idx;
         nack_ff    <= nxt_nack;
         pre_ff     <= nxt_pre;
         post_ff    <= nxt_post;
         addr_ff    <= nxt_addr;
         word_ff    <= nxt_word;
         cmd_ff     <= nxt_cmd;
         cmd_vld_ff <= nxt_cmd_vld;
         srst_ff    <= nxt_srst;
         latch_ff   <= nxt_latch;
      end
   end

   // ============================================================
   // Data-ready output; a new result wins over a same-cycle latch
   wire rdy_set   = result_valid && (hold_ff == 12'h000);
   wire rdy_clr   = latch_ff || (release_req && rdy_oe_ff);
   wire [11:0] nxt_hold = (release_req && rdy_oe_ff) ? RDY_CYC :
                          ((hold_ff != 12'h000) ? hold_ff - 12'h001 : 12'h000);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdy_oe_ff <= 1'b0;
         pend_ff   <= 1'b0;
         hold_ff   <= 12'h000;
      end
      else
      begin
         hold_ff   <= nxt_hold;
         pend_ff   <= (pend_ff || (result_valid && !rdy_set)) && (hold_ff != 12'h000);
         rdy_oe_ff <= rdy_set || (pend_ff && hold_ff == 12'h000) || (rdy_oe_ff && !rdy_clr);
      end
   end

   // ============================================================
   // Activity and busy towards the timeout domain
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act_tgl_ff <= 1'b0;
         busy_ff    <= 1'b0;
      end
      else
      begin
         act_tgl_ff <= act_tgl_ff ^ (line_act | stop_det);
         busy_ff    <= (nxt_state != ST_IDLE);
      end
   end

   // ============================================================
   // Timeout counter on the modulator clock
   logic [1:0]           busy_m_ff;
   logic [1:0]           turbo_m_ff;
   logic [2:0]           act_m_ff;
   logic [TIMEOUT_W-1:0] to_cnt_ff;
   logic                 to_tgl_ff;
   wire                  act_m   = act_m_ff[2] ^ act_m_ff[1];
   wire [TIMEOUT_W-1:0]  to_lim  = turbo_m_ff[1] ? TO_TURBO : TO_NORMAL;
   wire                  to_hit  = busy_m_ff[1] && (to_cnt_ff == to_lim - 1'b1);

   always_ff @(posedge clk_mod or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_m_ff  <= 2'h0;
         turbo_m_ff <= 2'h0;
         act_m_ff   <= 3'h0;
         to_cnt_ff  <= '0;
         to_tgl_ff  <= 1'b0;
      end
      else
      begin
         busy_m_ff  <= {busy_m_ff[0], busy_ff};
         turbo_m_ff <= {turbo_m_ff[0], turbo_mode};
         act_m_ff   <= {act_m_ff[1:0], act_tgl_ff};
         to_cnt_ff  <= (!busy_m_ff[1] || act_m || to_hit) ? '0 :
                       to_cnt_ff + 1'b1;
         to_tgl_ff  <= to_tgl_ff ^ to_hit;
      end
   end

   // Timeout event back into the system domain
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         to_sync_ff <= 3'h0;
      else
         to_sync_ff <= {to_sync_ff[1:0], to_tgl_ff};
   end

   // ============================================================
   // Outputs; data line only pulled low, clock never driven
   assign sda_out            = 1'b0;
   assign sda_oe             = oe_ff;
   assign result_ready_n_out = 1'b0;
   assign result_ready_n_oe  = rdy_oe_ff;
   assign cmd_byte           = cmd_ff;
   assign cmd_valid          = cmd_vld_ff;
   assign soft_reset         = srst_ff;
   assign own_addr           = addr_ff;

endmodule

/* aitp_chk_sva.sv */
/* Checker of the target port pins and outputs.
   Bound to every aitp_target_port instance; sees its ports only. */
`timescale 1ns/1ps
module aitp_chk
   import aitp_pkg::*;
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // Bus lines
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   // Ready and conversion path
   input wire logic       result_ready_n_out,
   input wire logic       result_ready_n_oe,
   input wire logic       result_valid,
   input wire logic       release_req,
   // Command side
   input wire logic       cmd_valid,
   input wire logic       soft_reset,
   input wire logic [6:0] own_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ============================================================
   // Steps of clock hold and ready release
   sequence scl_held;
      scl_in ##1 scl_in;
   endsequence
   sequence rel_taken;
      release_req && result_ready_n_oe && !result_valid;
   endsequence
   // ============================================================
   // Pin rules
   AST_OPEN_DRAIN: assert property (!sda_out && !result_ready_n_out)
      else $error("Open-drain pin driven high");
   AST_OE_STABLE: assert property (scl_held |-> $stable(sda_oe))
      else $error("Data drive changed with clock high");
   AST_OE_RISE: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("Data drive began with clock high");
   AST_OE_FALL: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("Data drive ended with clock high");
   AST_OE_BOUND: assert property (sda_oe |-> ##[1:1000] !sda_oe)
      else $error("Data line held low too long");
   AST_PREFIX: assert property (own_addr[6:4] == ADDR_PREFIX)
      else $error("Own address prefix wrong");
   AST_CMD_PULSE: assert property (cmd_valid |-> !scl_in ##1 !cmd_valid)
      else $error("Command strobe misplaced");
   AST_RST_PULSE: assert property (soft_reset |-> !scl_in ##1 !soft_reset)
      else $error("Reset strobe misplaced");
   AST_RDY_WINDOW: assert property (rel_taken |-> ##2 !result_ready_n_oe [*8])
      else $error("Ready not released");
endmodule
bind aitp_target_port aitp_chk u_chk (.clk_sys, .rst_n, .scl_in, .sda_out, .sda_oe,
   .result_ready_n_out, .result_ready_n_oe, .result_valid, .release_req, .cmd_valid,
   .soft_reset, .own_addr);

/* aitp_host_model.sv */
/* Bus controller model: START, STOP and byte transfers.
   Assumes pull-ups on both lines; the bench forms the wired data level. */
`timescale 1ns/1ps
module aitp_host_model
(
   // Clock
   input  wire logic clk,
   // Bus levels
   input  wire logic sda_w,
   output logic      scl_o,
   output logic      sda_o
);
   // Idle bus: clock stands high, data released
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Half clock periods 200 ns high, 250 ns low; about 2.2 Mbps, above 1 Mbps
   task automatic wt(input int n); repeat (n) @(posedge clk); #1; endtask
   // Data falls while clock high
   task automatic start();
      sda_o = 1'b1; wt(20); scl_o = 1'b1; wt(20); sda_o = 1'b0; wt(20); scl_o = 1'b0;
   endtask
   // Data rises while clock high, then bus-free wait
   task automatic stop();
      wt(5); sda_o = 1'b0; wt(20); scl_o = 1'b1; wt(20); sda_o = 1'b1; wt(40);
   endtask
   // Data changes only with clock low; sampled at end of high phase
   task automatic clk_bit(input logic b, output logic r);
      wt(5); sda_o = b; wt(20); scl_o = 1'b1; wt(20); r = sda_w; scl_o = 1'b0;
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
      clk_bit(a, ack);
   endtask
endmodule

/* adc_i2c_target_port_bench.sv */
/* Self-checking bench of the target port.
   Assumes the design files and the host model are compiled first. */
`timescale 1ns/1ps
module adc_i2c_target_port_bench;
   import aitp_pkg::*;
   logic clk_sys, clk_mod, rst_n, turbo, rv, rr, ack;
   logic sda_oe, rdy_oe, cmd_valid, soft_reset, h_scl, h_sda;
   logic [1:0]  st_lo, st_hi;
   logic [7:0]  d, q, cmd_byte;
   logic [15:0] rd;
   logic [6:0]  own_addr, ea;
   wire         sda_w = h_sda & ~sda_oe;
   int          seed, n_mismatch, checks_done, n_cmd, n_rst, c0;
   // Strap ties: ground, supply, data line or clock line; live levels as arguments
   function automatic logic tie(input logic [1:0] c, input logic sd, input logic sc);
      return (c == STRAP_GND) ? 1'b0 : (c == STRAP_SUPPLY) ? 1'b1 : (c == STRAP_DATA) ? sd : sc;
   endfunction
   aitp_target_port #(.TIMEOUT_NORMAL(40), .TIMEOUT_TURBO(80)) DUT (.clk_sys, .rst_n,
      .clk_mod, .turbo_mode(turbo), .scl_in(h_scl), .sda_in(sda_w), .sda_out(), .sda_oe,
      .addr_strap_low(tie(st_lo, sda_w, h_scl)), .addr_strap_high(tie(st_hi, sda_w, h_scl)),
      .result_valid(rv), .result_data(rd), .release_req(rr), .result_ready_n_out(),
      .result_ready_n_oe(rdy_oe), .cmd_byte, .cmd_valid, .soft_reset, .own_addr);
   aitp_host_model host (.clk(clk_sys), .sda_w, .scl_o(h_scl), .sda_o(h_sda));
   // Clocks: 10 ns system, 30 ns modulator
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      clk_mod = 1'b0;
      #7;
      forever #15 clk_mod = ~clk_mod;
   end
   // Strobe counters
   always @(posedge clk_sys)
   begin
      n_cmd <= n_cmd + cmd_valid;
      n_rst <= n_rst + soft_reset;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic pulse(input logic r);
      @(posedge clk_sys); #1; if (r) rr = 1'b1; else rv = 1'b1;
      @(posedge clk_sys); #1; rr = 1'b0; rv = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #800000;
      n_mismatch++;
      report_and_stop();
   end
   // ============================================================
   // Main sequence
   initial
   begin
      seed = 32'h4c4b; rst_n = 0; rv = 0; rr = 0; rd = 0; turbo = 0; st_lo = 0; st_hi = 0;
      repeat (20) @(posedge clk_sys); #1; rst_n = 1; repeat (10) @(posedge clk_sys); #1;
      chk(own_addr, 7'h40);
      for (int i = 0; i < 6; i++)
      begin
         st_lo = $random(seed); st_hi = $random(seed); d = $random(seed);
         rd = $random(seed); turbo = $random(seed); ea = {ADDR_PREFIX, st_hi, st_lo};
         if (i == 0) d = GCALL_RESET;
         host.start(); host.xfer({ea, 1'b0}, 1, q, ack); chk(ack, 0);
         chk(own_addr, ea);
         c0 = n_cmd; host.xfer(d, 1, q, ack); chk(ack, 0);
         chk(16'(n_cmd - c0), 1); chk(cmd_byte, d); host.stop();
         pulse(0); chk(rdy_oe, 1);
         host.start(); host.xfer({ea, 1'b1}, 1, q, ack); chk(rdy_oe, 0); chk(ack, 0);
         host.xfer(8'hFF, 0, q, ack); chk(q, rd[15:8]);
         host.xfer(8'hFF, 1, q, ack); chk(q, rd[7:0]); host.stop();
         host.start(); host.xfer({ea ^ 7'h10, 1'b0}, 1, q, ack); chk(ack, 1);
         host.stop();
      end
      host.start(); host.xfer({GCALL_ADDR, 1'b0}, 1, q, ack); chk(ack, 0);
      c0 = n_rst; host.xfer(GCALL_RESET, 1, q, ack); chk(ack, 0);
      chk(16'(n_rst - c0), 1); host.stop();
      host.start(); host.xfer({GCALL_ADDR, 1'b1}, 1, q, ack); chk(ack, 1); host.stop();
      pulse(0); pulse(1); repeat (5) @(posedge clk_sys); pulse(0); chk(rdy_oe, 0);
      repeat (210) @(posedge clk_sys); #1; chk(rdy_oe, 1);
      host.start(); d = {ea, 1'b0};
      for (int b = 7; b >= 0; b--) host.clk_bit(d[b], ack);
      repeat (10) @(posedge clk_sys); #1; chk(sda_oe, 1);
      repeat (390) @(posedge clk_sys); #1; chk(sda_oe, 0);
      host.start(); host.xfer({ea, 1'b0}, 1, q, ack); chk(ack, 0); host.stop();
      report_and_stop();
   end
endmodule
